// file: cdc_ctrl.sv
// Control, supervision and management bus slave of the dual cable driver
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A low chain_reset_in holds the block in reset with default settings and chain_reset_out low.
// - Writing register 0 drives chain_reset_out high, where it stays until chain_reset_in goes low.
// - Once set, chain_reset_out returns to zero only through a chain reset.
// - A low enable powers off both drivers and enters deep power save; high is normal operation.
// - An undriven enable pin counts as high, so the block runs normally.
// - The open-drain fault flag is pulled low while signal loss or any termination fault stands.
// - A high slew_select selects the slow edge rate and a low one the bus-set rate, fast by default.
// - The bus slew setting acts only while slew_select is low; a high pin forces slow edges.
// - Signal loss is declared when the input lacks a video-like edge density, rejecting oscillation and noise.
// - On signal loss the input offset is added or the outputs muted by bus choice, offset by default.
// - With the link option set, signal loss forces the internal enable low.
// - With signal present and an output amplitude too high, that output's termination fault asserts.
// - A termination fault deasserts once proper termination is sensed again.
// - Termination faults are evaluated only while the drivers are enabled.
// - The bus clock is only an input and the bus data line is only driven low, open drain.
// - Each fault source can be masked from the combined fault flag.
module cdc_ctrl #(
	parameter int LOS_WIN_CYC = cdc_pkg::CDC_LOS_WIN_CYC,
	parameter int LOS_EDGE_MIN = cdc_pkg::CDC_LOS_EDGE_MIN,
	parameter int LOS_EDGE_MAX = cdc_pkg::CDC_LOS_EDGE_MAX
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chain_reset_in,
	input wire logic enable_pin,
	input wire logic enable_driven,
	input wire logic slew_select,
	input wire logic serial_video_input,
	input wire logic [3:0] amp_high,
	input wire logic smb_scl,
	input wire logic smb_sda_in,
	output logic smb_sda_out,
	output logic smb_sda_oe,
	output logic fault_out,
	output logic fault_oe,
	output logic chain_reset_out,
	output cdc_pkg::cdc_drv_t drv,
	output logic [3:0] term_fault,
	output logic input_signal_absent,
	output logic irq,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	localparam int WIN_W = $clog2(LOS_WIN_CYC + 1);

	logic [cdc_pkg::CDC_PIN_W-1:0] pin_raw, pin_s1, pin_s2, pin_d;
	logic dev_rst, los_reg, en_pin_eff, en_eff, fault_active, wr_any;
	logic [6:0] id_reg;
	cdc_pkg::cdc_ctrl_t ctrl_reg;
	logic [4:0] fmask_reg;
	logic [2:0] istat_reg, imask_reg, ev, bcnt_reg;
	logic [3:0] tf_reg;
	logic [WIN_W-1:0] win_cnt, edge_cnt;
	logic [7:0] wr_addr, wr_data, rd_ptr, sh_reg, tx_reg, ptr_reg;
	cdc_pkg::cdc_smb_state_t st_reg, after_reg;
	logic full_reg, mack_reg, smb_wr_reg, scl_rise, scl_fall, smb_start, smb_stop, sda_s;

	// Pin synchroniser; only the second stage and its delayed copy feed logic
	assign pin_raw = {amp_high, smb_sda_in, smb_scl, serial_video_input, slew_select,
		enable_driven, enable_pin, chain_reset_in};

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_d <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	// Chain reset puts the whole device back to defaults
	assign dev_rst = rst | ~pin_s2[cdc_pkg::CDC_PIN_CRI];

	// Internal pullup: an undriven pin reads as enabled
	assign en_pin_eff = pin_s2[cdc_pkg::CDC_PIN_END] ? pin_s2[cdc_pkg::CDC_PIN_EN] : 1'b1;
	assign en_eff = en_pin_eff & ~(ctrl_reg.los_link & los_reg);

	// Register access; plain port wins a same-cycle collision with the bus slave
	assign wr_any = reg_wr | smb_wr_reg;
	assign wr_addr = reg_wr ? reg_addr : ptr_reg;
	assign wr_data = reg_wr ? reg_wdata : sh_reg;

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == cdc_pkg::CDC_OFS_ID) begin
			r = {id_reg, 1'b0};
		end else if (a == cdc_pkg::CDC_OFS_STATUS) begin
			r = {3'h0, tf_reg, los_reg};
		end else if (a == cdc_pkg::CDC_OFS_CTRL) begin
			r = {5'h00, ctrl_reg};
		end else if (a == cdc_pkg::CDC_OFS_FMASK) begin
			r = {3'h0, fmask_reg};
		end else if (a == cdc_pkg::CDC_OFS_ISTAT) begin
			r = {5'h00, istat_reg};
		end else if (a == cdc_pkg::CDC_OFS_IMASK) begin
			r = {5'h00, imask_reg};
		end
		return r;
	endfunction : rd_mux

	assign rd_ptr = rd_mux(ptr_reg);

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux(reg_addr);
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			id_reg <= cdc_pkg::CDC_ID_RST;
			ctrl_reg <= cdc_pkg::CDC_CTRL_RST;
			fmask_reg <= cdc_pkg::CDC_FMASK_RST;
			imask_reg <= cdc_pkg::CDC_IMASK_RST;
		end else if (wr_any) begin
			if (wr_addr == cdc_pkg::CDC_OFS_ID) begin
				id_reg <= wr_data[7:1];
			end else if (wr_addr == cdc_pkg::CDC_OFS_CTRL) begin
				ctrl_reg <= wr_data[2:0];
			end else if (wr_addr == cdc_pkg::CDC_OFS_FMASK) begin
				fmask_reg <= wr_data[4:0];
			end else if (wr_addr == cdc_pkg::CDC_OFS_IMASK) begin
				imask_reg <= wr_data[2:0];
			end
		end
	end

	// Chain output: set by any write of register 0, cleared only by chain reset
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			chain_reset_out <= 1'b0;
		end else if (wr_any && wr_addr == cdc_pkg::CDC_OFS_ID) begin
			chain_reset_out <= 1'b1;
		end
	end

	// Activity detector: too few edges is noise, too many is self oscillation
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			win_cnt <= '0;
			edge_cnt <= '0;
			los_reg <= 1'b1;
		end else if (win_cnt == WIN_W'(LOS_WIN_CYC - 1)) begin
			win_cnt <= '0;
			edge_cnt <= '0;
			los_reg <= (edge_cnt < WIN_W'(LOS_EDGE_MIN)) || (edge_cnt > WIN_W'(LOS_EDGE_MAX));
		end else begin
			win_cnt <= win_cnt + 1'b1;
			if (pin_s2[cdc_pkg::CDC_PIN_SVI] != pin_d[cdc_pkg::CDC_PIN_SVI]) begin
				edge_cnt <= edge_cnt + 1'b1;
			end
		end
	end

	// Termination sense per output leg
	generate
		for (genvar i = 0; i < 4; i++) begin : g_tf
			always_ff @(posedge mclk) begin
				if (dev_rst || !en_eff) begin
					tf_reg[i] <= 1'b0;
				end else if (!pin_s2[cdc_pkg::CDC_PIN_AMP + i]) begin
					tf_reg[i] <= 1'b0;
				end else if (!los_reg) begin
					tf_reg[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// Driver controls
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			drv <= '0;
		end else begin
			drv.drv_on <= en_eff;
			drv.deep_save <= ~en_eff;
			drv.slew_slow <= pin_s2[cdc_pkg::CDC_PIN_SLEW] | ctrl_reg.slew_slow;
			drv.input_offset <= los_reg & ~ctrl_reg.los_mute;
			drv.output_mute <= los_reg & ctrl_reg.los_mute;
		end
	end

	// Fault flag, open drain: only ever drives low
	assign fault_active = (los_reg & ~fmask_reg[0]) | (|(tf_reg & ~fmask_reg[4:1]));

	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_out <= 1'b0;
			fault_oe <= 1'b0;
			term_fault <= 4'h0;
			input_signal_absent <= 1'b1;
		end else begin
			fault_out <= 1'b0;
			fault_oe <= fault_active & ~dev_rst;
			term_fault <= dev_rst ? 4'h0 : tf_reg;
			input_signal_absent <= dev_rst | los_reg;
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	assign ev[cdc_pkg::CDC_EV_LOS_ON] = los_reg & ~drv.input_offset & ~drv.output_mute;
	assign ev[cdc_pkg::CDC_EV_LOS_OFF] = ~los_reg & (drv.input_offset | drv.output_mute);
	assign ev[cdc_pkg::CDC_EV_TF_ON] = |(tf_reg & ~term_fault);

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			istat_reg <= cdc_pkg::CDC_ISTAT_RST;
		end else if (wr_any && wr_addr == cdc_pkg::CDC_OFS_ISTAT) begin
			istat_reg <= (istat_reg & ~wr_data[2:0]) | ev;
		end else begin
			istat_reg <= istat_reg | ev;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat_reg & imask_reg);
		end
	end

	// Management bus slave; clock pin is sampled only, data only pulled low
	assign sda_s = pin_s2[cdc_pkg::CDC_PIN_SDA];
	assign scl_rise = pin_s2[cdc_pkg::CDC_PIN_SCL] & ~pin_d[cdc_pkg::CDC_PIN_SCL];
	assign scl_fall = ~pin_s2[cdc_pkg::CDC_PIN_SCL] & pin_d[cdc_pkg::CDC_PIN_SCL];
	assign smb_start = pin_s2[cdc_pkg::CDC_PIN_SCL] & pin_d[cdc_pkg::CDC_PIN_SCL] &
		pin_d[cdc_pkg::CDC_PIN_SDA] & ~sda_s;
	assign smb_stop = pin_s2[cdc_pkg::CDC_PIN_SCL] & pin_d[cdc_pkg::CDC_PIN_SCL] &
		~pin_d[cdc_pkg::CDC_PIN_SDA] & sda_s;

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			st_reg <= cdc_pkg::CDC_S_IDLE;
			after_reg <= cdc_pkg::CDC_S_IDLE;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			bcnt_reg <= 3'h0;
			full_reg <= 1'b0;
			mack_reg <= 1'b0;
			smb_wr_reg <= 1'b0;
			smb_sda_oe <= 1'b0;
			smb_sda_out <= 1'b0;
		end else begin
			smb_wr_reg <= 1'b0;
			smb_sda_out <= 1'b0;
			if (smb_start) begin
				st_reg <= cdc_pkg::CDC_S_DEV;
				bcnt_reg <= 3'h0;
				full_reg <= 1'b0;
				smb_sda_oe <= 1'b0;
			end else if (smb_stop) begin
				st_reg <= cdc_pkg::CDC_S_IDLE;
				smb_sda_oe <= 1'b0;
			end else begin
				case (st_reg)
					cdc_pkg::CDC_S_DEV, cdc_pkg::CDC_S_PTR, cdc_pkg::CDC_S_DATA: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bcnt_reg <= bcnt_reg + 1'b1;
							full_reg <= (bcnt_reg == 3'h7);
						end else if (scl_fall && full_reg) begin
							full_reg <= 1'b0;
							if (st_reg == cdc_pkg::CDC_S_DEV) begin
								if (sh_reg[7:1] == id_reg) begin
									smb_sda_oe <= 1'b1;
									st_reg <= cdc_pkg::CDC_S_ACK;
									after_reg <= sh_reg[0] ? cdc_pkg::CDC_S_SEND : cdc_pkg::CDC_S_PTR;
								end else begin
									st_reg <= cdc_pkg::CDC_S_IDLE;
								end
							end else if (st_reg == cdc_pkg::CDC_S_PTR) begin
								ptr_reg <= sh_reg;
								smb_sda_oe <= 1'b1;
								st_reg <= cdc_pkg::CDC_S_ACK;
								after_reg <= cdc_pkg::CDC_S_DATA;
							end else begin
								smb_wr_reg <= 1'b1;
								smb_sda_oe <= 1'b1;
								st_reg <= cdc_pkg::CDC_S_ACK;
								after_reg <= cdc_pkg::CDC_S_DATA;
							end
						end
					end
					cdc_pkg::CDC_S_ACK: begin
						if (scl_fall) begin
							st_reg <= after_reg;
							bcnt_reg <= 3'h0;
							if (after_reg == cdc_pkg::CDC_S_SEND) begin
								tx_reg <= rd_ptr;
								smb_sda_oe <= ~rd_ptr[7];
							end else begin
								smb_sda_oe <= 1'b0;
							end
						end
					end
					cdc_pkg::CDC_S_SEND: begin
						if (scl_rise) begin
							bcnt_reg <= bcnt_reg + 1'b1;
							full_reg <= (bcnt_reg == 3'h7);
						end else if (scl_fall) begin
							if (full_reg) begin
								full_reg <= 1'b0;
								smb_sda_oe <= 1'b0;
								st_reg <= cdc_pkg::CDC_S_MACK;
							end else begin
								tx_reg <= {tx_reg[6:0], 1'b0};
								smb_sda_oe <= ~tx_reg[6];
							end
						end
					end
					cdc_pkg::CDC_S_MACK: begin
						if (scl_rise) begin
							mack_reg <= ~sda_s;
						end else if (scl_fall) begin
							if (mack_reg) begin
								tx_reg <= rd_ptr;
								smb_sda_oe <= ~rd_ptr[7];
								bcnt_reg <= 3'h0;
								st_reg <= cdc_pkg::CDC_S_SEND;
							end else begin
								st_reg <= cdc_pkg::CDC_S_IDLE;
							end
						end
					end
					default: begin
						st_reg <= cdc_pkg::CDC_S_IDLE;
					end
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_chain_out_low: assert property (dev_rst |=> !chain_reset_out)
		else $error("chain output not low in chain reset");
	chk_chain_out_set: assert property (!dev_rst && wr_any && wr_addr == cdc_pkg::CDC_OFS_ID
		##1 !dev_rst |-> chain_reset_out)
		else $error("chain output not set by id write");
	chk_chain_out_hold: assert property (chain_reset_out && !dev_rst |=> chain_reset_out)
		else $error("chain output dropped without chain reset");
	chk_power_save: assert property (!dev_rst && !en_pin_eff |=> drv.deep_save && !drv.drv_on)
		else $error("drivers not powered off with enable low");
	chk_enable_pullup: assert property (!dev_rst && !pin_s2[cdc_pkg::CDC_PIN_END] &&
		!(ctrl_reg.los_link && los_reg) |=> drv.drv_on)
		else $error("undriven enable not treated as high");
	chk_fault_flag: assert property (!dev_rst ##1 !$past(dev_rst) |->
		fault_oe == $past(fault_active))
		else $error("fault flag does not follow fault sources");
	chk_fault_mask: assert property (!dev_rst && fmask_reg[0] && tf_reg == 4'h0 |=> !fault_oe)
		else $error("masked signal loss still pulls the fault flag");
	chk_slew_pin: assert property (!dev_rst && pin_s2[cdc_pkg::CDC_PIN_SLEW] |=> drv.slew_slow)
		else $error("high slew pin did not force slow edges");
	chk_slew_bus: assert property (!dev_rst && !pin_s2[cdc_pkg::CDC_PIN_SLEW] |=>
		drv.slew_slow == $past(ctrl_reg.slew_slow))
		else $error("bus slew setting not applied with pin low");
	chk_los_action: assert property (!dev_rst && los_reg |=>
		(drv.output_mute == $past(ctrl_reg.los_mute)) && (drv.input_offset != drv.output_mute))
		else $error("wrong loss of signal action");
	chk_link_disable: assert property (!dev_rst && ctrl_reg.los_link && los_reg |=> !drv.drv_on)
		else $error("link option did not disable drivers");
	chk_tf_off: assert property (!en_eff |=> tf_reg == 4'h0)
		else $error("termination fault while drivers disabled");
	chk_tf_clear: assert property (1'b1 |=> (tf_reg & ~$past(pin_s2[10:7])) == 4'h0)
		else $error("termination fault held after proper termination");
	chk_sda_odrain: assert property (smb_sda_oe |-> !smb_sda_out)
		else $error("bus data driven high");

	cov_chain_release: cover property (!chain_reset_out ##1 chain_reset_out);
	cov_los_mute: cover property (ctrl_reg.los_mute && los_reg ##1 drv.output_mute);
	cov_tf_set: cover property (tf_reg == 4'h0 ##1 tf_reg != 4'h0);
	cov_smb_read: cover property (st_reg == cdc_pkg::CDC_S_MACK ##1 st_reg == cdc_pkg::CDC_S_SEND);
endmodule : cdc_ctrl
`default_nettype wire

// file: cdc_pkg.sv
// Package for the cable driver control block: offsets, resets, states, carriers
`default_nettype none
package cdc_pkg;
	// Register offsets on the plain register port and over the management bus
	localparam logic [7:0] CDC_OFS_ID = 8'h00;
	localparam logic [7:0] CDC_OFS_STATUS = 8'h01;
	localparam logic [7:0] CDC_OFS_CTRL = 8'h02;
	localparam logic [7:0] CDC_OFS_FMASK = 8'h03;
	localparam logic [7:0] CDC_OFS_ISTAT = 8'h04;
	localparam logic [7:0] CDC_OFS_IMASK = 8'h05;

	// Values after reset
	localparam logic [6:0] CDC_ID_RST = 7'h17;
	localparam logic [4:0] CDC_FMASK_RST = 5'h00;
	localparam logic [2:0] CDC_ISTAT_RST = 3'h0;
	localparam logic [2:0] CDC_IMASK_RST = 3'h0;

	// Positions inside the synchronised pin vector
	localparam int CDC_PIN_W = 11;
	localparam int CDC_PIN_CRI = 0;
	localparam int CDC_PIN_EN = 1;
	localparam int CDC_PIN_END = 2;
	localparam int CDC_PIN_SLEW = 3;
	localparam int CDC_PIN_SVI = 4;
	localparam int CDC_PIN_SCL = 5;
	localparam int CDC_PIN_SDA = 6;
	localparam int CDC_PIN_AMP = 7;

	// Interrupt status bit positions
	localparam int CDC_EV_LOS_ON = 0;
	localparam int CDC_EV_LOS_OFF = 1;
	localparam int CDC_EV_TF_ON = 2;

	// Activity detector defaults, counts of mclk cycles and edges
	localparam int CDC_LOS_WIN_CYC = 256;
	localparam int CDC_LOS_EDGE_MIN = 8;
	localparam int CDC_LOS_EDGE_MAX = 200;

	// Management bus slave states
	typedef enum logic [6:0] {
		CDC_S_IDLE = 7'h01,
		CDC_S_DEV = 7'h02,
		CDC_S_PTR = 7'h04,
		CDC_S_DATA = 7'h08,
		CDC_S_ACK = 7'h10,
		CDC_S_SEND = 7'h20,
		CDC_S_MACK = 7'h40
	} cdc_smb_state_t;

	// Control register layout
	typedef struct packed {
		logic los_link;
		logic los_mute;
		logic slew_slow;
	} cdc_ctrl_t;

	localparam cdc_ctrl_t CDC_CTRL_RST = '{los_link: 1'b0, los_mute: 1'b0, slew_slow: 1'b0};

	// Driver control outputs toward the analog stage
	typedef struct packed {
		logic drv_on;
		logic deep_save;
		logic slew_slow;
		logic input_offset;
		logic output_mute;
	} cdc_drv_t;
endpackage : cdc_pkg
`default_nettype wire

// file: cdc_cable_model.sv
// Behavioural serial source and coaxial load facing the cable driver block
`timescale 1ns/1ps
`default_nettype none
module cdc_cable_model (
	input wire logic mclk,
	input wire cdc_pkg::cdc_drv_t drv,
	input wire logic [1:0] src_mode,
	input wire logic [1:0] term_ok,
	output logic serial_video_input,
	output logic [3:0] amp_high
);
	logic [1:0] div_reg = 2'h0;
	logic line_reg = 1'b0;
	logic swing;
	// Mode 0 quiet line, 1 video-like edges, 2 toggling on every cycle
	always_ff @(posedge mclk) begin
		div_reg <= div_reg + 2'h1;
		if ((src_mode == 2'h1 && div_reg == 2'h0) || src_mode == 2'h2) begin
			line_reg <= ~line_reg;
		end
	end
	assign serial_video_input = line_reg;
	// A powered-off driver shows no swing, open or terminated
	assign swing = drv.drv_on & (src_mode != 2'h0);
	// Open output reads too high on both of its comparators
	assign amp_high = {{2{swing & ~term_ok[1]}}, {2{swing & ~term_ok[0]}}};
endmodule : cdc_cable_model
`default_nettype wire

// file: tb_cdc_ctrl.sv
// Self-checking bench for the cable driver control block
`timescale 1ns/1ps
`default_nettype none
module tb_cdc_ctrl;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic chain_reset_in = 1'b1;
	logic enable_pin = 1'b1;
	logic enable_driven = 1'b0;
	logic slew_select = 1'b0;
	logic [1:0] src_mode = 2'h0;
	logic [1:0] term_ok = 2'h3;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic serial_video_input, smb_sda_out, smb_sda_oe, fault_out, fault_oe;
	logic chain_reset_out, input_signal_absent, irq;
	logic [3:0] amp_high, term_fault;
	logic [7:0] reg_rdata, rd_val;
	cdc_pkg::cdc_drv_t drv;
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	logic sda_line, smb_ack;
	logic [7:0] smb_q;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;

	initial begin
		forever #25 mclk = ~mclk;
	end

	// Pulled-up data wire: low while either side pulls it
	assign sda_line = sda_m & ~(smb_sda_oe & ~smb_sda_out);

	// Short window keeps the run brief; low ceiling makes fast toggling count as oscillation
	cdc_ctrl #(.LOS_WIN_CYC(64), .LOS_EDGE_MIN(8), .LOS_EDGE_MAX(40)) dut_u (
		.mclk(mclk), .rst(rst), .chain_reset_in(chain_reset_in),
		.enable_pin(enable_pin), .enable_driven(enable_driven), .slew_select(slew_select),
		.serial_video_input(serial_video_input), .amp_high(amp_high),
		.smb_scl(scl_m), .smb_sda_in(sda_line), .smb_sda_out(smb_sda_out), .smb_sda_oe(smb_sda_oe),
		.fault_out(fault_out), .fault_oe(fault_oe), .chain_reset_out(chain_reset_out),
		.drv(drv), .term_fault(term_fault), .input_signal_absent(input_signal_absent),
		.irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	cdc_cable_model cable_u (
		.mclk(mclk), .drv(drv), .src_mode(src_mode), .term_ok(term_ok),
		.serial_video_input(serial_video_input), .amp_high(amp_high)
	);

	task automatic conclude();
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wait_cyc

	// Two-wire master; six clocks per phase, above the slave's minimum of four
	task automatic smb_bit(input logic b, output logic s);
		@(posedge mclk);
		sda_m <= b;
		repeat (6) @(posedge mclk);
		scl_m <= 1'b1;
		repeat (3) @(posedge mclk);
		s = sda_line;
		repeat (3) @(posedge mclk);
		scl_m <= 1'b0;
	endtask : smb_bit

	task automatic smb_start();
		@(posedge mclk);
		sda_m <= 1'b1;
		repeat (6) @(posedge mclk);
		scl_m <= 1'b1;
		repeat (6) @(posedge mclk);
		sda_m <= 1'b0;
		repeat (6) @(posedge mclk);
		scl_m <= 1'b0;
	endtask : smb_start

	task automatic smb_stop();
		@(posedge mclk);
		sda_m <= 1'b0;
		repeat (6) @(posedge mclk);
		scl_m <= 1'b1;
		repeat (6) @(posedge mclk);
		sda_m <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask : smb_stop

	// Ninth bit released: slave acknowledge on writes, master no-acknowledge on reads
	task automatic smb_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			smb_bit(d[k], s);
			q[k] = s;
		end
		smb_bit(1'b1, s);
		ack = ~s;
	endtask : smb_byte

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		wait_cyc(4);
		chk({7'h0, chain_reset_out}, 8'h00);
		rd(cdc_pkg::CDC_OFS_ID);
		chk(rd_val, {cdc_pkg::CDC_ID_RST, 1'b0});
		wr(cdc_pkg::CDC_OFS_ID, 8'h2C);
		wait_cyc(2);
		chk({7'h0, chain_reset_out}, 8'h01);
		rd(cdc_pkg::CDC_OFS_ID);
		chk(rd_val, 8'h2C);
		wr(cdc_pkg::CDC_OFS_CTRL, 8'h00);
		wait_cyc(3);
		chk({7'h0, chain_reset_out}, 8'h01);
		@(posedge mclk) chain_reset_in <= 1'b0;
		wait_cyc(4);
		chk({6'h0, chain_reset_out, input_signal_absent}, 8'h01);
		chk({3'h0, drv}, 8'h00);
		wr(cdc_pkg::CDC_OFS_ID, 8'h20);
		@(posedge mclk) chain_reset_in <= 1'b1;
		wait_cyc(4);
		rd(cdc_pkg::CDC_OFS_ID);
		chk(rd_val, 8'h2E);
		// Undriven enable pin counts as high: driver on, offset added on loss
		chk({3'h0, drv}, 8'h12);
		chk({7'h0, chain_reset_out}, 8'h00);
		// Same address change over the two-wire bus, then read back
		smb_start();
		smb_byte(8'h2E, smb_q, smb_ack);
		chk({7'h0, smb_ack}, 8'h01);
		smb_byte(8'h00, smb_q, smb_ack);
		chk({7'h0, smb_ack}, 8'h01);
		smb_byte(8'h2C, smb_q, smb_ack);
		chk({7'h0, smb_ack}, 8'h01);
		smb_stop();
		chk({7'h0, chain_reset_out}, 8'h01);
		smb_start();
		smb_byte(8'h2C, smb_q, smb_ack);
		smb_byte(8'h00, smb_q, smb_ack);
		smb_start();
		smb_byte(8'h2D, smb_q, smb_ack);
		chk({7'h0, smb_ack}, 8'h01);
		smb_byte(8'hFF, smb_q, smb_ack);
		chk(smb_q, 8'h2C);
		smb_stop();
		// Old address no longer answers
		smb_start();
		smb_byte(8'h2E, smb_q, smb_ack);
		chk({7'h0, smb_ack}, 8'h00);
		smb_stop();
		@(posedge mclk) enable_driven <= 1'b1;
		@(posedge mclk) enable_pin <= 1'b0;
		wait_cyc(4);
		chk({3'h0, drv}, 8'h0A);
		@(posedge mclk) enable_pin <= 1'b1;
		wait_cyc(4);
		chk({3'h0, drv}, 8'h12);
		for (int i = 0; i < 4; i++) begin
			wr(cdc_pkg::CDC_OFS_CTRL, {7'h0, i[0]});
			@(posedge mclk) slew_select <= i[1];
			wait_cyc(4);
			chk({7'h0, drv.slew_slow}, {7'h0, i[1] | i[0]});
		end
		wr(cdc_pkg::CDC_OFS_CTRL, 8'h00);
		@(posedge mclk) slew_select <= 1'b0;
		// Quiet line, video-like edges, then oscillation
		for (int m = 0; m < 3; m++) begin
			@(posedge mclk) src_mode <= 2'(m);
			wait_cyc(200);
			chk({7'h0, input_signal_absent}, {7'h0, m != 1});
			chk({7'h0, drv.input_offset}, {7'h0, m != 1});
		end
		rd(cdc_pkg::CDC_OFS_ISTAT);
		chk(rd_val, 8'h03);
		chk({7'h0, irq}, 8'h00);
		wr(cdc_pkg::CDC_OFS_IMASK, 8'h01);
		wait_cyc(3);
		chk({7'h0, irq}, 8'h01);
		wr(cdc_pkg::CDC_OFS_ISTAT, 8'h01);
		wr(8'h7F, 8'hFF);
		rd(8'h7F);
		chk(rd_val, 8'h00);
		rd(cdc_pkg::CDC_OFS_ISTAT);
		chk(rd_val, 8'h02);
		chk({6'h0, irq, fault_oe}, 8'h01);
		chk({6'h0, smb_sda_oe, smb_sda_out}, 8'h00);
		chk({7'h0, fault_out}, 8'h00);
		wr(cdc_pkg::CDC_OFS_FMASK, 8'h01);
		wait_cyc(3);
		chk({7'h0, fault_oe}, 8'h00);
		wr(cdc_pkg::CDC_OFS_FMASK, 8'h00);
		wr(cdc_pkg::CDC_OFS_CTRL, 8'h02);
		wait_cyc(3);
		chk({3'h0, drv}, 8'h11);
		wr(cdc_pkg::CDC_OFS_CTRL, 8'h04);
		wait_cyc(3);
		chk({7'h0, drv.drv_on}, 8'h00);
		@(posedge mclk) src_mode <= 2'h1;
		wait_cyc(200);
		chk({7'h0, drv.drv_on}, 8'h01);
		wr(cdc_pkg::CDC_OFS_CTRL, 8'h00);
		// Open output A, then terminate it again
		@(posedge mclk) term_ok <= 2'h2;
		wait_cyc(8);
		chk({3'h0, term_fault, fault_oe}, 8'h07);
		rd(cdc_pkg::CDC_OFS_STATUS);
		chk(rd_val, 8'h06);
		wr(cdc_pkg::CDC_OFS_FMASK, 8'h06);
		wait_cyc(3);
		chk({7'h0, fault_oe}, 8'h00);
		wr(cdc_pkg::CDC_OFS_FMASK, 8'h00);
		@(posedge mclk) term_ok <= 2'h3;
		wait_cyc(8);
		chk({3'h0, term_fault, fault_oe}, 8'h00);
		@(posedge mclk) term_ok <= 2'h1;
		wait_cyc(8);
		chk({4'h0, term_fault}, 8'h0C);
		@(posedge mclk) enable_pin <= 1'b0;
		wait_cyc(8);
		chk({4'h0, term_fault}, 8'h00);
		conclude();
	end
endmodule : tb_cdc_ctrl
`default_nettype wire
